// >>> rtl/ordering_unit.sv
// memory ordering unit for one thread's load/store path, apb register slave
// assumes pipeline and memory-side strobes are on pclk; ops are held until op_done
//
// Behaviour
// - a full fence orders all earlier accesses before all later ones
// - predecessor set holds loads iff pr bit, stores iff pw bit
// - successor set holds loads iff sr bit, stores iff sw bit
// - fences with empty predecessor or successor set impose no ordering
// - the total-store-order fence encoding is recognised and enforced
// - atomic or conditional store values reach loads only after global perform
// - swap and conditional-store values are forwarded from the store buffer only once performed, failed conditional stores never
// - same-address loads seeing different stores stay in program order
// - same-address loads may reorder while no invalidation hits them
// - overlap checks fire on partial overlap and differing base addresses
// - misaligned accesses are checked piece by piece
// - an acquire access precedes every later access globally
// - a read-to-any fence orders all earlier loads, not one access
// - fence ordering is kept per thread, with no cumulativity tracking
// - a later store never passes the most recent earlier access if that access overlaps it and is not yet performed
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "ordering_defines.svh"

module ordering_unit
    import ordering_pkg::*;
#(
    parameter int ADDR_W = 32,
    parameter int TAG_W = 6,
    parameter int CNT_W = 6,
    parameter int SPEC_N = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // op issue
    input wire logic op_valid,
    input wire ordering_pkg::op_kind_t op_kind,
    input wire logic op_aq,
    input wire logic [ADDR_W-1:0] op_addr,
    input wire logic [`LEN_W-1:0] op_len,
    input wire logic [3:0] op_fence_bits,
    input wire logic op_fence_tso,
    output logic op_done,
    output logic [TAG_W-1:0] op_tag,
    // global perform reports
    input wire logic perf_valid,
    input wire ordering_pkg::op_kind_t perf_kind,
    input wire logic [TAG_W-1:0] perf_tag,
    // store buffer forwarding query
    input wire logic fwd_valid,
    input wire ordering_pkg::op_kind_t fwd_kind,
    input wire logic fwd_performed,
    input wire logic fwd_sc_ok,
    output logic fwd_answer,
    output logic fwd_allow,
    // early-performed younger loads and invalidations
    input wire logic early_valid,
    input wire logic [TAG_W-1:0] early_tag,
    input wire logic [ADDR_W-1:0] early_addr,
    input wire logic [`LEN_W-1:0] early_len,
    input wire logic retire_valid,
    input wire logic [TAG_W-1:0] retire_tag,
    input wire logic inv_valid,
    input wire logic [ADDR_W-1:0] inv_addr,
    input wire logic [`LEN_W-1:0] inv_len,
    output logic spec_full,
    output logic squash_valid,
    output logic [TAG_W-1:0] squash_tag
);
    import ordering_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic ctrl_fwd_en_q;
    logic [31:0] squash_cnt_q;
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;
    logic [CNT_W-1:0] ld_cnt_q, st_cnt_q;
    fence_st_t fence_st_q;
    logic fpr_q, fpw_q, fsr_q, fsw_q, ftso_q;
    logic [6:0] fence_info_q;
    logic aq_pend_q;
    logic [TAG_W-1:0] aq_tag_q;
    logic last_vld_q;
    logic [TAG_W-1:0] last_tag_q;
    logic [ADDR_W-1:0] last_addr_q;
    logic [`LEN_W-1:0] last_len_q;
    logic [TAG_W-1:0] tag_q;
    logic op_done_q, fwd_answer_q, fwd_allow_q, spec_full_q, squash_valid_q;
    logic [TAG_W-1:0] squash_tag_q;
    logic [SPEC_N-1:0] sp_vld_q;
    logic [TAG_W-1:0] sp_tag_q [SPEC_N];
    logic [ADDR_W-1:0] sp_addr_q [SPEC_N];
    logic [`LEN_W-1:0] sp_len_q [SPEC_N];

    // ----------------------------------------
    // fence decode and overlap helpers
    // ----------------------------------------
    fence_if fdec ();
    access_if #(.ADDR_W(ADDR_W)) acc_new ();
    access_if #(.ADDR_W(ADDR_W)) acc_last ();
    access_if #(.ADDR_W(ADDR_W)) acc_inv ();
    wire last_hit;
    wire [SPEC_N-1:0] inv_hit;

    assign fdec.bits = op_fence_bits;
    assign fdec.tso = op_fence_tso;
    assign acc_new.addr = op_addr;
    assign acc_new.len = op_len;
    assign acc_last.addr = last_addr_q;
    assign acc_last.len = last_len_q;
    assign acc_inv.addr = inv_addr;
    assign acc_inv.len = inv_len;

    fence_decoder u_fdec (.f(fdec));
    overlap_checker #(.ADDR_W(ADDR_W)) u_last (.a(acc_new), .b(acc_last), .hit(last_hit));

    genvar gi;
    generate
        for (gi = 0; gi < SPEC_N; gi++) begin : g_spec
            access_if #(.ADDR_W(ADDR_W)) acc_sp ();
            assign acc_sp.addr = sp_addr_q[gi];
            assign acc_sp.len = sp_len_q[gi];
            overlap_checker #(.ADDR_W(ADDR_W)) u_chk (.a(acc_sp), .b(acc_inv), .hit(inv_hit[gi]));
        end
    endgenerate

    // ----------------------------------------
    // issue gating
    // ----------------------------------------
    wire is_ld, is_st, is_fence, ld_pend, st_pend, pred_busy;
    wire blk_fence, blk_store, op_take, fence_take, fence_arm;
    assign is_ld = op_kind == OP_LOAD || op_kind == OP_AMO;
    assign is_st = op_kind == OP_STORE || op_kind == OP_SC || op_kind == OP_AMO;
    assign is_fence = op_kind == OP_FENCE;
    assign ld_pend = ld_cnt_q != '0;
    assign st_pend = st_cnt_q != '0;
    assign pred_busy = (fpr_q && ld_pend) || (fpw_q && st_pend);
    // tso: later loads wait on loads only, later stores on everything
    assign blk_fence = fence_st_q == FS_WAIT && (ftso_q
        ? ((is_ld && ld_pend) || (is_st && (ld_pend || st_pend)))
        : (pred_busy && ((is_ld && fsr_q) || (is_st && fsw_q))));
    assign blk_store = is_st && last_vld_q && last_hit;
    // one fence at a time; an acquire blocks all later accesses
    assign op_take = op_valid && !op_done_q && !aq_pend_q && !(is_fence && fence_st_q == FS_WAIT)
        && !blk_fence && !blk_store;
    assign fence_take = op_take && is_fence;
    assign fence_arm = fence_take && !fdec.noop;

    // ----------------------------------------
    // pending counts, kept for this thread only
    // ----------------------------------------
    wire ld_inc, st_inc, ld_dec, st_dec;
    assign ld_inc = op_take && is_ld;
    assign st_inc = op_take && is_st;
    assign ld_dec = perf_valid && (perf_kind == OP_LOAD || perf_kind == OP_AMO);
    assign st_dec = perf_valid && (perf_kind == OP_STORE || perf_kind == OP_SC || perf_kind == OP_AMO);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ld_cnt_q <= '0;
            st_cnt_q <= '0;
        end else begin
            ld_cnt_q <= ld_cnt_q + CNT_W'(ld_inc) - CNT_W'(ld_dec);
            st_cnt_q <= st_cnt_q + CNT_W'(st_inc) - CNT_W'(st_dec);
        end
    end

    // ----------------------------------------
    // fence state
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fence_st_q <= FS_IDLE;
            {fpr_q, fpw_q, fsr_q, fsw_q, ftso_q} <= '0;
            fence_info_q <= '0;
        end else begin
            unique case (fence_st_q)
                FS_IDLE: if (fence_arm) begin
                    fence_st_q <= FS_WAIT;
                    {fpr_q, fpw_q, fsr_q, fsw_q} <= {fdec.pr, fdec.pw, fdec.sr, fdec.sw};
                    ftso_q <= fdec.tso;
                end
                FS_WAIT: if (!pred_busy) begin
                    fence_st_q <= FS_IDLE;
                end
            endcase
            if (fence_take) begin
                fence_info_q <= {fdec.rsvd, fdec.noop, fdec.tso, op_fence_bits};
            end
        end
    end

    // ----------------------------------------
    // acquire and last-access tracking
    // ----------------------------------------
    wire acc_take;
    assign acc_take = op_take && !is_fence;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aq_pend_q <= 1'b0;
            aq_tag_q <= '0;
            last_vld_q <= 1'b0;
            last_tag_q <= '0;
            last_addr_q <= '0;
            last_len_q <= '0;
            tag_q <= '0;
        end else begin
            if (acc_take && op_aq) begin
                aq_pend_q <= 1'b1;
                aq_tag_q <= tag_q;
            end else if (perf_valid && perf_tag == aq_tag_q) begin
                aq_pend_q <= 1'b0;
            end
            // a new access wins over the perform of the old one
            if (acc_take) begin
                last_vld_q <= 1'b1;
                last_tag_q <= tag_q;
                last_addr_q <= op_addr;
                last_len_q <= op_len;
            end else if (perf_valid && perf_tag == last_tag_q) begin
                last_vld_q <= 1'b0;
            end
            if (acc_take) begin
                tag_q <= tag_q + TAG_W'(1);
            end
        end
    end

    // ----------------------------------------
    // forwarding decision
    // ----------------------------------------
    wire fwd_ok;
    // swap values are amo values too, so they never forward early
    assign fwd_ok = ctrl_fwd_en_q && (fwd_kind == OP_STORE
        || ((fwd_kind == OP_AMO || fwd_kind == OP_SC) && fwd_performed
            && (fwd_kind != OP_SC || fwd_sc_ok)));

    // ----------------------------------------
    // early-load table
    // ----------------------------------------
    logic [SPEC_N-1:0] free_onehot, hit_onehot;
    logic [TAG_W-1:0] hit_tag;
    always_comb begin
        free_onehot = '0;
        hit_onehot = '0;
        hit_tag = '0;
        for (int i = SPEC_N - 1; i >= 0; i--) begin
            if (!sp_vld_q[i]) begin
                free_onehot = SPEC_N'(1) << i;
            end
            if (sp_vld_q[i] && inv_valid && inv_hit[i]) begin
                hit_onehot = SPEC_N'(1) << i;
                hit_tag = sp_tag_q[i];
            end
        end
    end
    wire inv_any;
    assign inv_any = hit_onehot != '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_vld_q <= '0;
            squash_valid_q <= 1'b0;
            squash_tag_q <= '0;
        end else begin
            for (int i = 0; i < SPEC_N; i++) begin
                if (early_valid && free_onehot[i]) begin
                    sp_vld_q[i] <= 1'b1;
                end else if (hit_onehot[i] || (retire_valid && sp_tag_q[i] == retire_tag)) begin
                    sp_vld_q[i] <= 1'b0;
                end
            end
            squash_valid_q <= inv_any;
            squash_tag_q <= hit_tag;
        end
    end

    always_ff @(posedge pclk) begin
        for (int i = 0; i < SPEC_N; i++) begin
            if (early_valid && free_onehot[i]) begin
                sp_tag_q[i] <= early_tag;
                sp_addr_q[i] <= early_addr;
                sp_len_q[i] <= early_len;
            end
        end
    end

    // ----------------------------------------
    // apb slave, one wait state
    // ----------------------------------------
    wire apb_req, apb_wr, apb_rd, addr_ok;
    logic [31:0] rd_mux;
    assign apb_req = psel && penable && !pready_q;
    assign apb_wr = psel && penable && pready_q && pwrite && !pslverr_q;
    assign addr_ok = paddr == `REG_CTRL || paddr == `REG_STATUS || paddr == `REG_SQUASH_CNT
        || paddr == `REG_FENCE_INFO;
    assign apb_rd = apb_req && !pwrite;

    always_comb begin
        rd_mux = '0;
        unique case (paddr)
            `REG_CTRL: rd_mux[`CTRL_FWD_EN] = ctrl_fwd_en_q;
            `REG_STATUS: begin
                rd_mux[`ST_FENCE_WAIT] = fence_st_q == FS_WAIT;
                rd_mux[`ST_AQ_PEND] = aq_pend_q;
                rd_mux[`ST_LAST_VLD] = last_vld_q;
                rd_mux[`ST_SPEC_FULL] = spec_full_q;
                rd_mux[`ST_LD_LSB +: CNT_W] = ld_cnt_q;
                rd_mux[`ST_ST_LSB +: CNT_W] = st_cnt_q;
            end
            `REG_SQUASH_CNT: rd_mux = squash_cnt_q;
            `REG_FENCE_INFO: rd_mux[`FI_BITS_LSB +: 7] = fence_info_q;
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
            ctrl_fwd_en_q <= `CTRL_RST;
            squash_cnt_q <= '0;
        end else begin
            pready_q <= apb_req;
            pslverr_q <= apb_req && !addr_ok;
            prdata_q <= apb_rd ? rd_mux : '0;
            if (apb_wr && paddr == `REG_CTRL) begin
                ctrl_fwd_en_q <= pwdata[`CTRL_FWD_EN];
            end
            if (squash_valid_q) begin
                squash_cnt_q <= squash_cnt_q + 32'h1;
            end else if (apb_wr && paddr == `REG_CTRL && pwdata[`CTRL_CNT_CLR]) begin
                squash_cnt_q <= '0;
            end
        end
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_done_q <= 1'b0;
            fwd_answer_q <= 1'b0;
            fwd_allow_q <= 1'b0;
            spec_full_q <= 1'b0;
        end else begin
            op_done_q <= op_take;
            fwd_answer_q <= fwd_valid;
            fwd_allow_q <= fwd_valid && fwd_ok;
            spec_full_q <= &sp_vld_q;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign op_done = op_done_q;
    assign op_tag = last_tag_q;
    assign fwd_answer = fwd_answer_q;
    assign fwd_allow = fwd_allow_q;
    assign spec_full = spec_full_q;
    assign squash_valid = squash_valid_q;
    assign squash_tag = squash_tag_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence apb_access;
        psel && penable && !pready_q;
    endsequence
    sequence fence_idle_next;
        ##1 fence_st_q == FS_IDLE;
    endsequence

    apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        apb_access |=> pready_q ##1 !pready_q) else $error("apb answer not one wait state");
    fence_release_a: assert property (@(posedge pclk) disable iff (!presetn)
        fence_st_q == FS_WAIT && !pred_busy |-> fence_idle_next) else $error("fence held with no predecessors");
    noop_fence_a: assert property (@(posedge pclk) disable iff (!presetn)
        fence_take && fdec.noop |-> fence_idle_next) else $error("no-op fence armed");
    fence_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        op_take && op_kind == OP_LOAD && fence_st_q == FS_WAIT && !ftso_q && fpr_q && ld_pend |-> !fsr_q)
        else $error("load passed a read fence");
    tso_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        op_take && op_kind == OP_LOAD && fence_st_q == FS_WAIT && ftso_q |-> ld_cnt_q == '0)
        else $error("load passed tso fence with loads pending");
    aq_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        aq_pend_q && !(perf_valid && perf_tag == aq_tag_q) |=> aq_pend_q && !op_take)
        else $error("access passed an acquire");
    fwd_amo_a: assert property (@(posedge pclk) disable iff (!presetn)
        fwd_valid && fwd_kind != OP_STORE && !fwd_performed |=> fwd_answer_q && !fwd_allow_q)
        else $error("atomic value forwarded before perform");
    fwd_sc_a: assert property (@(posedge pclk) disable iff (!presetn)
        fwd_valid && fwd_kind == OP_SC && !fwd_sc_ok |=> !fwd_allow_q) else $error("failed sc forwarded");
    squash_hit_a: assert property (@(posedge pclk) disable iff (!presetn)
        inv_any |=> squash_valid_q && squash_tag_q == $past(hit_tag)) else $error("overlapping invalidate not squashed");
    no_squash_a: assert property (@(posedge pclk) disable iff (!presetn)
        !inv_any |=> !squash_valid_q) else $error("squash without invalidate");
    store_order_a: assert property (@(posedge pclk) disable iff (!presetn)
        op_take && is_st && last_vld_q |-> !last_hit) else $error("store passed overlapping access");
endmodule : ordering_unit

// >>> shared/ordering_defines.svh
// named offsets, field positions, reset values and sizes for the ordering unit
// assumes inclusion by bare name from every file that needs a number
`ifndef ORDERING_DEFINES_SVH
`define ORDERING_DEFINES_SVH

// ----------------------------------------
// register map, byte addresses
// ----------------------------------------
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_SQUASH_CNT 12'h008
`define REG_FENCE_INFO 12'h00c

// ----------------------------------------
// fields
// ----------------------------------------
`define CTRL_FWD_EN 0
`define CTRL_CNT_CLR 1
`define CTRL_RST 1'b1
`define ST_FENCE_WAIT 0
`define ST_AQ_PEND 1
`define ST_LAST_VLD 2
`define ST_SPEC_FULL 3
`define ST_LD_LSB 8
`define ST_ST_LSB 16
`define FI_BITS_LSB 0
`define FI_TSO 4
`define FI_NOOP 5
`define FI_RSVD 6

// fence bit order within the four-bit field
`define FB_PR 3
`define FB_PW 2
`define FB_SR 1
`define FB_SW 0

// ----------------------------------------
// fence forms in common use
// ----------------------------------------
`define FENCE_RW_RW 4'hf
`define FENCE_RW_W 4'hd
`define FENCE_R_RW 4'hb
`define FENCE_R_R 4'ha
`define FENCE_W_W 4'h5

// ----------------------------------------
// sizes
// ----------------------------------------
`define PIECE_BYTES 8
`define LEN_W 4

`endif

// >>> shared/ordering_pkg.sv
// types shared by the ordering unit and its helpers
// assumes nothing beyond the defines header
package ordering_pkg;
    typedef enum logic [2:0] {OP_LOAD, OP_STORE, OP_AMO, OP_SC, OP_FENCE} op_kind_t;
    typedef enum logic {FS_IDLE, FS_WAIT} fence_st_t;
endpackage : ordering_pkg

// >>> shared/ordering_ifs.sv
// carriers between the ordering unit and its helpers
// assumes one clock domain; purely combinational bundles
`timescale 1ns/1ps
`include "ordering_defines.svh"

interface access_if #(parameter int ADDR_W = 32);
    logic [ADDR_W-1:0] addr;
    logic [`LEN_W-1:0] len;
    modport src (output addr, output len);
    modport dst (input addr, input len);
endinterface : access_if

interface fence_if;
    logic [3:0] bits;
    logic tso;
    logic pr;
    logic pw;
    logic sr;
    logic sw;
    logic noop;
    logic rsvd;
    modport dec (input bits, input tso, output pr, output pw, output sr, output sw, output noop, output rsvd);
    modport user (output bits, output tso, input pr, input pw, input sr, input sw, input noop, input rsvd);
endinterface : fence_if

// >>> rtl/fence_decoder.sv
// fence bit decoder: predecessor and successor classes, no-op and reserved forms
// assumes a settled four-bit field and total-store-order flag from the issuing stage
`timescale 1ns/1ps
`include "ordering_defines.svh"

module fence_decoder (
    // decoded fence
    fence_if.dec f
);
    wire common_form;

    // tso form orders loads before all and stores before stores
    assign f.pr = f.tso | f.bits[`FB_PR];
    assign f.pw = f.tso | f.bits[`FB_PW];
    assign f.sr = f.tso | f.bits[`FB_SR];
    assign f.sw = f.tso | f.bits[`FB_SW];
    // an empty side leaves nothing to order
    assign f.noop = !f.tso && (!(f.bits[`FB_PR] | f.bits[`FB_PW]) || !(f.bits[`FB_SR] | f.bits[`FB_SW]));
    assign common_form = f.tso || f.bits == `FENCE_RW_RW || f.bits == `FENCE_RW_W || f.bits == `FENCE_R_RW
        || f.bits == `FENCE_R_R || f.bits == `FENCE_W_W;
    // reserved forms are still honoured as written, only flagged
    assign f.rsvd = !f.noop && !common_form;
endmodule : fence_decoder

// >>> rtl/overlap_checker.sv
// byte-range overlap test, access a split into pieces at piece boundaries
// assumes lengths of 1 to PIECE_BYTES bytes
`timescale 1ns/1ps
`include "ordering_defines.svh"

module overlap_checker #(
    parameter int ADDR_W = 32
) (
    // the split access and the probe range
    access_if.dst a,
    access_if.dst b,
    // result
    output logic hit
);
    localparam int PB = `PIECE_BYTES;

    function automatic logic ranges_meet(input logic [ADDR_W:0] s1, input logic [ADDR_W:0] e1,
                                         input logic [ADDR_W:0] s2, input logic [ADDR_W:0] e2);
        ranges_meet = (s1 < e2) && (s2 < e1);
    endfunction : ranges_meet

    wire [ADDR_W:0] a_s;
    wire [ADDR_W:0] a_e;
    wire [ADDR_W:0] b_s;
    wire [ADDR_W:0] b_e;
    wire [ADDR_W:0] bound;
    wire split;
    wire [ADDR_W:0] p0_e;

    assign a_s = {1'b0, a.addr};
    assign a_e = a_s + (ADDR_W+1)'(a.len);
    assign b_s = {1'b0, b.addr};
    assign b_e = b_s + (ADDR_W+1)'(b.len);
    // next piece boundary above the start
    assign bound = (a_s & ~(ADDR_W+1)'(PB - 1)) + (ADDR_W+1)'(PB);
    assign split = a_e > bound;
    assign p0_e = split ? bound : a_e;
    // partial overlap counts, any base address
    assign hit = ranges_meet(a_s, p0_e, b_s, b_e) || (split && ranges_meet(bound, a_e, b_s, b_e));
endmodule : overlap_checker

// >>> test/mem_model.sv
// memory side: reports global perform of each issued access, in issue order
// assumes op_kind and op_tag hold the issued access while op_done is high
`timescale 1ns/1ps
module mem_model
    import ordering_pkg::*;
(
    // hold high models a slow memory
    input wire logic pclk,
    input wire logic hold,
    input wire logic op_done,
    input wire ordering_pkg::op_kind_t op_kind,
    input wire logic [5:0] op_tag,
    output ordering_pkg::op_kind_t perf_kind = OP_LOAD,
    output logic perf_valid = 0,
    output logic [5:0] perf_tag = 0
);
    op_kind_t kq[$];
    logic [5:0] tq[$];
    always @(posedge pclk) begin
        if (op_done && op_kind != OP_FENCE) kq.push_back(op_kind);
        if (op_done && op_kind != OP_FENCE) tq.push_back(op_tag);
        if (!hold && kq.size() > 0) begin
            perf_valid <= 1;
            perf_kind <= kq.pop_front();
            perf_tag <= tq.pop_front();
        end else begin
            perf_valid <= 0;
            perf_tag <= ~perf_tag;
        end
    end
endmodule : mem_model

// >>> test/tb_top.sv
// bench: apb, issue stalls, forwarding and squash of the ordering unit
// assumes mem_model performs in issue order while hold is low
`timescale 1ns/1ps
`include "ordering_defines.svh"
module tb_top;
    import ordering_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, hold = 0, op_valid = 0, op_aq = 0, er;
    logic op_fence_tso = 0, fwd_valid = 0, fwd_performed = 0, fwd_sc_ok = 0, early_valid = 0, inv_valid = 0;
    logic retire_valid = 0, pready, pslverr, op_done, perf_valid, fwd_answer, fwd_allow, spec_full, squash_valid;
    logic [31:0] pwdata = 0, prdata, op_addr = 0, early_addr = 32'h500, inv_addr = 0, rd;
    logic [11:0] paddr = 0;
    logic [3:0] op_len = 1, op_fence_bits = 0, early_len = 4, inv_len = 2;
    logic [5:0] op_tag, perf_tag, early_tag = 0, retire_tag = 0, squash_tag;
    op_kind_t op_kind = OP_LOAD, fwd_kind = OP_LOAD, perf_kind;
    int failures = 0, n_compared = 0, tags = 0;
    initial forever #4 pclk = ~pclk;
    initial #400us give_verdict(1);
    ordering_unit ordering_unit_i (.*);
    mem_model mem_model_i (.*);
    task automatic chk(string s, logic [39:0] x, logic [39:0] g);
        n_compared++;
        failures += (g !== x);
        if (g !== x) $display("BAD %s exp %h got %h", s, x, g);
    endtask : chk
    task automatic give_verdict(int to);
        failures += to;
        if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1);
        {er, rd} = {pslverr, prdata};
        {psel, penable} <= 0;
    endtask : apb
    // blk above zero: memory stalls, op must not finish within blk cycles
    task automatic op(op_kind_t k, logic [31:0] a, logic [3:0] l, logic [3:0] b, int blk, logic h, logic aq = 0);
        int n = 0;
        if (h && !hold) repeat (8) @(posedge pclk);
        @(posedge pclk);
        hold <= h;
        op_kind <= k;
        {op_valid, op_addr, op_len, op_fence_bits, op_aq, op_fence_tso} <= {1'b1, a, l, b, aq, aq};
        do begin
            @(negedge pclk);
            if (++n == blk) hold <= 0;
        end while (op_done !== 1 && n < 300);
        if (k != OP_FENCE) chk("tag", tags++, op_tag);
        @(posedge pclk);
        op_valid <= 0;
        chk("op", 1, n < 300 && (blk > 0 ? n > blk : n == 2));
    endtask : op
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        apb(0, 12'h010, 0);
        chk("unmapped", 40'h100000000, {er, rd});
        for (int i = 0; i < 16; i++) begin
            op(OP_FENCE, 0, 1, i[3:0], 0, 0);
            apb(0, `REG_FENCE_INFO, 0);
            chk("fi", {!(i inside {15, 13, 11, 10, 5}) && i[3:2] && i[1:0], !(i[3:2] && i[1:0]), 1'b0, i[3:0]},
                rd[6:0]);
        end
        for (int i = 0; i < 32; i++) begin
            if (i == 16) apb(1, `REG_CTRL, 32'h0);
            @(posedge pclk);
            {fwd_valid, fwd_performed, fwd_sc_ok} <= {1'b1, i[1:0]};
            fwd_kind <= op_kind_t'(i[3:2]);
            @(posedge pclk);
            fwd_valid <= 0;
            @(negedge pclk);
            chk("fwd", {1'b1, !i[4] && (i[3:2] == 1 || i[3] && i[1] && (!i[2] || i[0]))},
                {fwd_answer, fwd_allow});
        end
        apb(0, `REG_CTRL, 32'h0);
        chk("ctrl", 0, rd);
        apb(1, `REG_CTRL, 32'h1);
        op(OP_LOAD, 32'h40, 4, 0, 0, 1);
        op(OP_FENCE, 0, 1, `FENCE_R_R, 0, 1);
        op(OP_STORE, 32'h80, 4, 0, 0, 1);
        op(OP_LOAD, 32'h90, 4, 0, 4, 1);
        op(OP_STORE, 32'h100, 8, 0, 0, 1);
        op(OP_LOAD, 32'h104, 4, 0, 0, 1);
        op(OP_STORE, 32'h106, 4, 0, 3, 1);
        op(OP_LOAD, 32'h300, 4, 0, 0, 1, 1);
        op(OP_STORE, 32'h400, 8, 0, 3, 1);
        op(OP_STORE, 32'h600, 4, 0, 0, 1);
        op(OP_FENCE, 0, 1, 0, 0, 1, 1);
        apb(0, `REG_FENCE_INFO, 32'h0);
        chk("fi", 7'h10, rd[6:0]);
        apb(0, `REG_STATUS, 32'h0);
        chk("status", 32'h10005, rd);
        op(OP_LOAD, 32'h700, 4, 0, 0, 1);
        op(OP_STORE, 32'h800, 4, 0, 3, 1);
        @(posedge pclk);
        {early_valid, early_tag} <= 7'h45;
        @(posedge pclk);
        {early_valid, inv_valid, inv_addr} <= {2'b01, 32'h504};
        @(posedge pclk);
        inv_addr <= 32'h503;
        @(negedge pclk);
        chk("squash", 7'h00, {squash_valid, squash_tag});
        @(posedge pclk);
        inv_valid <= 0;
        @(negedge pclk);
        chk("squash", 7'h45, {squash_valid, squash_tag});
        apb(0, `REG_SQUASH_CNT, 32'h0);
        chk("sqcnt", 1, rd);
        apb(1, `REG_CTRL, 32'h3);
        apb(0, `REG_SQUASH_CNT, 32'h0);
        chk("sqcnt", 0, rd);
        @(posedge pclk);
        early_valid <= 1;
        repeat (4) @(posedge pclk);
        early_valid <= 0;
        apb(0, `REG_STATUS, 32'h0);
        chk("status", 32'h8, rd);
        chk("full", 1, spec_full);
        {retire_valid, retire_tag} <= 7'h45;
        @(posedge pclk);
        retire_valid <= 0;
        repeat (2) @(negedge pclk);
        chk("full", 0, spec_full);
        give_verdict(0);
    end
endmodule : tb_top
